//--- design/fspg_guard.sv
// Flash self-program guard with a classic Wishbone register slave.
//
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/100ps

module fspg_guard (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire fspg_pkg::fspg_req_t req_i,
  output fspg_pkg::fspg_resp_t resp_o
);

  // ==========================================================
  // State record.
  typedef struct packed {
    fspg_pkg::fspg_phase_t phase;
    logic [7:0] count;
    logic busy_flag;
    logic reject;
    logic [3:0] locks;
    logic [1:0] size;
    logic vec_boot;
    logic [1:0] gen_lock;
    logic [31:0] rdata;
    logic ack;
    fspg_pkg::fspg_resp_t resp;
  } fspg_state_t;

  fspg_state_t st;
  fspg_state_t next_st;

  // Combinational decode signals.
  logic [13:0] boot_base;
  logic pc_in_boot;
  logic addr_in_boot;
  logic addr_in_rww;
  logic app_wr_block;
  logic app_rd_block;
  logic boot_wr_block;
  logic boot_rd_block;
  logic store_allowed;
  logic load_allowed;
  logic fetch_allowed;
  logic rww_blocked;
  logic bus_req;

  // ==========================================================
  // Region decode and lock evaluation.
  always_comb
  begin
    // Boot region start picked by size; every choice is at or above halt base.
    unique case (st.size)
      2'h0: boot_base = fspg_pkg::BOOT_BASE_0;
      2'h1: boot_base = fspg_pkg::BOOT_BASE_1;
      2'h2: boot_base = fspg_pkg::BOOT_BASE_2;
      2'h3: boot_base = fspg_pkg::BOOT_BASE_3;
    endcase
    pc_in_boot = (req_i.pc >= boot_base);
    addr_in_boot = (req_i.addr >= boot_base);
    // Region is taken from the target address of the operation.
    addr_in_rww = (req_i.addr < fspg_pkg::HALT_REGION_BASE);
    // Application locks: high bit 0 blocks loads from boot code, low bit 0 blocks stores.
    app_wr_block = !st.locks[fspg_pkg::BIT_APP_LOW];
    app_rd_block = !st.locks[fspg_pkg::BIT_APP_HIGH] && pc_in_boot;
    // Boot locks mirror the application ones.
    boot_wr_block = !st.locks[fspg_pkg::BIT_BOOT_LOW];
    boot_rd_block = !st.locks[fspg_pkg::BIT_BOOT_HIGH] && !pc_in_boot;
    // The general lock setting is deliberately not consulted here.
    store_allowed = pc_in_boot &&
      !(addr_in_boot ? boot_wr_block : app_wr_block);
    rww_blocked = st.busy_flag;
    load_allowed = !(addr_in_boot ? boot_rd_block : app_rd_block) &&
      !(rww_blocked && addr_in_rww);
    // Fetches from the unblocked halting region stay alive.
    fetch_allowed = !(rww_blocked && addr_in_rww);
    bus_req = wb_cyc_i && wb_stb_i && !st.ack;
  end

  // ==========================================================
  // Next-state logic for sequencing and the register bus.
  always_comb
  begin
    next_st = st;
    next_st.ack = bus_req;
    next_st.resp.resume = 1'b0;
    next_st.resp.prog_done = 1'b0;
    // Programming sequencer.
    unique case (st.phase)
      fspg_pkg::FSPG_IDLE:
      begin
        if (req_i.prog && req_i.store)
        begin
          if (store_allowed)
          begin
            next_st.count = fspg_pkg::PROG_CYCLES;
            next_st.busy_flag = 1'b1;
            next_st.phase = addr_in_rww ? fspg_pkg::FSPG_RWW : fspg_pkg::FSPG_HALT;
          end
          else
          begin
            next_st.reject = 1'b1;
          end
        end
      end
      fspg_pkg::FSPG_RWW, fspg_pkg::FSPG_HALT:
      begin
        // Count down the operation time.
        next_st.count = st.count - 8'h01;
        if (st.count == 8'h01)
        begin
          next_st.phase = fspg_pkg::FSPG_IDLE;
          next_st.resp.prog_done = 1'b1;
          // Halt release tells the core to continue after the store.
          next_st.resp.resume = (st.phase == fspg_pkg::FSPG_HALT);
        end
      end
      default:
      begin
        next_st.phase = fspg_pkg::FSPG_IDLE;
      end
    endcase
    // Register writes.
    if (bus_req && wb_we_i && wb_sel_i[0])
    begin
      unique case (wb_adr_i)
        fspg_pkg::OFS_CTRL_STATUS:
        begin
          // Busy clears only once programming is over; software must do this.
          if (wb_dat_i[fspg_pkg::BIT_CLEAR_BUSY] && st.phase == fspg_pkg::FSPG_IDLE
              && next_st.phase == fspg_pkg::FSPG_IDLE)
            next_st.busy_flag = 1'b0;
          if (wb_dat_i[fspg_pkg::BIT_REJECT] && !(req_i.prog && req_i.store))
            next_st.reject = 1'b0;
        end
        fspg_pkg::OFS_LOCKS:
        begin
          // Lock bits may only go to zero unless a chip erase is asked.
          if (wb_sel_i[1] && wb_dat_i[fspg_pkg::BIT_CHIP_ERASE])
            next_st.locks = fspg_pkg::LOCKS_RESET;
          else
            next_st.locks = st.locks & wb_dat_i[3:0];
        end
        fspg_pkg::OFS_CONFIG:
        begin
          next_st.size = wb_dat_i[fspg_pkg::BIT_SIZE_LO +: 2];
          next_st.vec_boot = wb_dat_i[fspg_pkg::BIT_VEC_BOOT];
          next_st.gen_lock = wb_dat_i[fspg_pkg::BIT_GEN_LOCK_LO +: 2];
        end
        default:
        begin
          next_st.size = st.size;
        end
      endcase
    end
    // Register reads; unmapped offsets read zero.
    next_st.rdata = 32'h0000_0000;
    if (bus_req && !wb_we_i)
    begin
      unique case (wb_adr_i)
        fspg_pkg::OFS_CTRL_STATUS:
        begin
          next_st.rdata[fspg_pkg::BIT_BUSY_FLAG] = st.busy_flag;
          next_st.rdata[fspg_pkg::BIT_PROG_ACTIVE] = (st.phase != fspg_pkg::FSPG_IDLE);
          next_st.rdata[fspg_pkg::BIT_HALTED] = (st.phase == fspg_pkg::FSPG_HALT);
          next_st.rdata[fspg_pkg::BIT_REJECT] = st.reject;
        end
        fspg_pkg::OFS_LOCKS:
          next_st.rdata[3:0] = st.locks;
        fspg_pkg::OFS_CONFIG:
        begin
          next_st.rdata[fspg_pkg::BIT_SIZE_LO +: 2] = st.size;
          next_st.rdata[fspg_pkg::BIT_VEC_BOOT] = st.vec_boot;
          next_st.rdata[fspg_pkg::BIT_GEN_LOCK_LO +: 2] = st.gen_lock;
        end
        default:
          next_st.rdata = 32'h0000_0000;
      endcase
    end
    // Registered answers to the core; halt from the state being entered, the rest from the present state.
    next_st.resp.halt = (next_st.phase == fspg_pkg::FSPG_HALT);
    next_st.resp.read_ok = load_allowed && fetch_allowed;
    next_st.resp.store_ok = store_allowed;
    // Interrupt masking when vectors sit in the other region.
    next_st.resp.irq_mask =
      (!st.locks[fspg_pkg::BIT_APP_HIGH] && st.vec_boot && !pc_in_boot) ||
      (!st.locks[fspg_pkg::BIT_BOOT_HIGH] && !st.vec_boot && pc_in_boot);
  end

  // ==========================================================
  // State register.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st <= '0;
      st.phase <= fspg_pkg::FSPG_IDLE;
      st.locks <= fspg_pkg::LOCKS_RESET;
      st.size <= fspg_pkg::SIZE_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from the state record.
  assign wb_dat_o = st.rdata;
  assign wb_ack_o = st.ack;
  assign resp_o = st.resp;

endmodule

//--- design/fspg_pkg.sv
// Constants, layouts and types for the flash self-program guard.
package fspg_pkg;

  // ==========================================================
  // Address and data widths.
  localparam int ADDR_W = 14;
  localparam int DATA_W = 32;

  // Start of the halting region; the boot region starts at or above it.
  localparam logic [13:0] HALT_REGION_BASE = 14'h3800;

  // Boot region start per size setting, all inside the halting region.
  localparam logic [13:0] BOOT_BASE_0 = 14'h3800;
  localparam logic [13:0] BOOT_BASE_1 = 14'h3c00;
  localparam logic [13:0] BOOT_BASE_2 = 14'h3e00;
  localparam logic [13:0] BOOT_BASE_3 = 14'h3f00;

  // Duration of one page erase or write, in microseconds and cycles.
  localparam int PROG_TIME_US = 4;
  localparam int CLK_MHZ = 10;
  localparam logic [7:0] PROG_CYCLES = 8'(PROG_TIME_US * CLK_MHZ);

  // ==========================================================
  // Register byte offsets.
  localparam logic [3:0] OFS_CTRL_STATUS = 4'h0;
  localparam logic [3:0] OFS_LOCKS = 4'h4;
  localparam logic [3:0] OFS_CONFIG = 4'h8;

  // Field positions in the control and status register.
  localparam int BIT_BUSY_FLAG = 0;
  localparam int BIT_PROG_ACTIVE = 1;
  localparam int BIT_HALTED = 2;
  localparam int BIT_REJECT = 3;
  localparam int BIT_CLEAR_BUSY = 0;

  // Field positions in the lock register.
  localparam int BIT_APP_LOW = 0;
  localparam int BIT_APP_HIGH = 1;
  localparam int BIT_BOOT_LOW = 2;
  localparam int BIT_BOOT_HIGH = 3;
  localparam int BIT_CHIP_ERASE = 8;

  // Field positions in the configuration register.
  localparam int BIT_SIZE_LO = 0;
  localparam int BIT_VEC_BOOT = 2;
  localparam int BIT_GEN_LOCK_LO = 4;

  // Reset values.
  localparam logic [3:0] LOCKS_RESET = 4'hf;
  localparam logic [1:0] SIZE_RESET = 2'h0;

  // ==========================================================
  // Operation phase.
  typedef enum logic [1:0] {
    FSPG_IDLE = 2'b00,
    FSPG_RWW = 2'b01,
    FSPG_HALT = 2'b10
  } fspg_phase_t;

  // One request from the processor core.
  typedef struct packed {
    logic fetch;
    logic load;
    logic store;
    logic prog;
    logic [13:0] pc;
    logic [13:0] addr;
  } fspg_req_t;

  // Answers to the processor core.
  typedef struct packed {
    logic halt;
    logic read_ok;
    logic store_ok;
    logic irq_mask;
    logic resume;
    logic prog_done;
  } fspg_resp_t;

endpackage

//--- tb/fspg_core_model.sv
// Processor core model that turns bench commands into guard requests.
`timescale 1ns/100ps
module fspg_core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire fspg_pkg::fspg_req_t cmd_i,
  input wire fspg_pkg::fspg_resp_t resp_i,
  output fspg_pkg::fspg_req_t req_o
);
  // A halted core issues nothing; otherwise a command goes out one edge later.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || resp_i.halt)
      req_o <= '0;
    else
      req_o <= cmd_i;
  end
endmodule

//--- tb/fspg_guard_tb.sv
// Testbench for the flash self-program guard.
`timescale 1ns/100ps
module fspg_guard_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  fspg_pkg::fspg_req_t cmd = '0;
  fspg_pkg::fspg_req_t req_i;
  fspg_pkg::fspg_resp_t resp_o;
  int fails = 0;
  int samples_checked = 0;
  logic [31:0] rd; // Data taken by the last bus cycle.
  always #50 clk_i = ~clk_i;
  fspg_guard i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .req_i(req_i), .resp_o(resp_o));
  fspg_core_model i_core (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd), .resp_i(resp_o),
    .req_o(req_i));
  task automatic wrap_up;
    if (fails == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    check({31'h0, got}, {31'h0, exp});
  endtask
  // One classic cycle, held until ack is sampled high at an edge.
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'h3;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1)
    begin
      fails++;
      wrap_up();
    end
  endtask
  // Issues one core request; kind is fetch, load, store, prog.
  task automatic core(input logic [3:0] kind, input logic [13:0] pc, input logic [13:0] adr);
    @(posedge clk_i);
    cmd <= {kind, pc, adr};
    @(posedge clk_i);
    cmd <= '0;
    @(posedge clk_i);
    #1;
  endtask
  // Programs the region that keeps running, then frees it.
  task automatic t_rww;
    int n;
    core(4'h3, 14'h3800, 14'h0100);
    check_bit(resp_o.halt, 1'b0);
    core(4'h4, 14'h3800, 14'h0100);
    check_bit(resp_o.read_ok, 1'b0);
    core(4'h4, 14'h3800, 14'h3900);
    check_bit(resp_o.read_ok, 1'b1);
    for (n = 0; resp_o.prog_done !== 1'b1 && n < 60; n++)
      @(posedge clk_i) #1;
    check_bit(n < 60, 1'b1);
    wb(1'b0, 4'h0, 32'h0000_0000);
    check(rd, 32'h0000_0001);
    wb(1'b1, 4'h0, 32'h0000_0001);
    core(4'h4, 14'h3800, 14'h0100);
    check_bit(resp_o.read_ok, 1'b1);
  endtask
  // Programs the halting region and times the halt.
  task automatic t_halt;
    int n;
    core(4'h3, 14'h3800, 14'h3900);
    for (n = 0; resp_o.halt === 1'b1 && n < 60; n++)
      @(posedge clk_i) #1;
    check(n, 32'h0000_0028);
    check_bit(resp_o.resume, 1'b1);
    core(4'h3, 14'h0100, 14'h0200);
    check_bit(resp_o.store_ok, 1'b0);
    wb(1'b0, 4'h0, 32'h0000_0000);
    check(rd, 32'h0000_0009);
    wb(1'b1, 4'h0, 32'h0000_0009);
  endtask
  // Walks every mode of both lock sets after a chip erase.
  task automatic t_locks;
    logic [1:0] m [4] = '{2'b11, 2'b10, 2'b00, 2'b01};
    logic [13:0] own;
    logic [3:0] lk;
    for (int s = 0; s < 2; s++)
      for (int i = 0; i < 4; i++)
      begin
        own = s ? 14'h3f80 : 14'h0100;
        lk = s ? {m[i], 2'b11} : {2'b11, m[i]};
        wb(1'b1, 4'h4, 32'h0000_0100);
        wb(1'b1, 4'h4, {28'h0, lk});
        wb(1'b1, 4'h4, 32'h0000_000f);
        wb(1'b1, 4'h8, s ? 32'h0000_0020 : 32'h0000_0014);
        wb(1'b0, 4'h8, 32'h0000_0000);
        check(rd, s ? 32'h0000_0020 : 32'h0000_0014);
        wb(1'b0, 4'h4, 32'h0000_0000);
        check(rd, {28'h0, lk});
        core(4'h2, 14'h3800, own);
        check_bit(resp_o.store_ok, m[i][0]);
        core(4'h4, s ? 14'h0100 : 14'h3800, own);
        check_bit(resp_o.read_ok, m[i][1]);
        core(4'h8, own, own);
        check_bit(resp_o.irq_mask, ~m[i][1]);
      end
  endtask
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 4'h4, 32'h0000_0000);
    check(rd, 32'h0000_000f);
    wb(1'b0, 4'h c, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    t_rww();
    t_halt();
    t_locks();
    wrap_up();
  end
endmodule
bind fspg_guard fspg_props i_props (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .req_i(req_i),
  .resp_o(resp_o));

//--- tb/fspg_props.sv
// Checker for the guard's bus and core-link ports.
`timescale 1ns/100ps
module fspg_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire fspg_pkg::fspg_req_t req_i,
  input wire fspg_pkg::fspg_resp_t resp_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] halt_cnt; // Edges seen with the core halted.
  // Counts the length of the present halt.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !resp_o.halt)
      halt_cnt <= 8'h00;
    else
      halt_cnt <= halt_cnt + 8'h01;
  end
  // The end of a halting operation.
  sequence s_op_end;
    $fell(resp_o.halt);
  endsequence
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  chk_halt_cause: assert property ($rose(resp_o.halt) |->
    $past(req_i.prog && req_i.store && req_i.addr >= fspg_pkg::HALT_REGION_BASE))
    else $error("halt without halting-region store");
  chk_rww_runs: assert property (!resp_o.halt && req_i.prog && req_i.store &&
    req_i.addr < fspg_pkg::HALT_REGION_BASE |=> !resp_o.halt)
    else $error("core halted for region store");
  chk_halt_length: assert property (s_op_end |-> halt_cnt == fspg_pkg::PROG_CYCLES)
    else $error("halt length wrong");
  chk_resume_end: assert property (s_op_end |-> resp_o.resume && resp_o.prog_done)
    else $error("no resume at halt end");
  chk_store_boot: assert property (resp_o.store_ok |-> $past(req_i.pc) >= 14'h3800)
    else $error("store allowed outside boot");
  chk_rww_blocked: assert property (resp_o.halt && $past(resp_o.halt) &&
    $past(req_i.addr) < 14'h3800 |-> !resp_o.read_ok)
    else $error("blocked region readable");
endmodule
